// ### src/spi_burst_pkg.sv
// Constants, field positions and state types for the serial port with SRAM burst.
// Assumes a 10 MHz system clock and a 10-bit AXI4-Lite byte address (word index = address / 4).
package spi_burst_pkg;

	// Register word indices; byte address is index * 4
	localparam int ADDR_W = 10;
	localparam logic [7:0] IDX_TX_BASE = 8'h3E;
	localparam logic [7:0] IDX_RX_BASE = 8'h3F;
	localparam logic [7:0] IDX_CNT_LO = 8'h40;
	localparam logic [7:0] IDX_CNT_HI = 8'h41;
	localparam logic [7:0] IDX_PIN = 8'h68;
	localparam logic [7:0] IDX_RXCLK = 8'h69;
	localparam logic [7:0] IDX_CTRL1 = 8'hB5;
	localparam logic [7:0] IDX_CTRL2 = 8'hB6;
	localparam logic [7:0] IDX_FLAGS = 8'hBE;
	localparam logic [7:0] IDX_DATA = 8'hBF;
	localparam logic [7:0] IDX_IRQF = 8'hE1;
	localparam logic [7:0] IDX_IRQE = 8'hE7;
	localparam logic [7:0] IDX_IRQP = 8'hF4;

	// serial_control_one fields
	localparam int C1_FULL_IE = 7;
	localparam int C1_EN = 6;
	localparam int C1_EMPTY_IE = 5;
	localparam int C1_ROLE = 4;
	localparam int C1_POL = 3;
	localparam int C1_PHA = 2;
	localparam int C1_LSB = 1;
	localparam int C1_CS = 0;

	// serial_control_two fields
	localparam int C2_ECHO = 6;
	localparam int C2_GO = 5;
	localparam int C2_HALF = 4;
	localparam int C2_DIR = 3;

	// serial_flags fields
	localparam int ST_FULL = 2;
	localparam int ST_OVR = 1;
	localparam int ST_EMPTY = 0;

	// Port bit in the shared interrupt registers
	localparam int IRQ_BIT = 5;

	// Reset values
	localparam logic [7:0] CTRL1_RST = 8'h15;
	localparam logic [7:0] CTRL2_RST = 8'h18;
	localparam logic [2:0] FLAGS_RST = 3'h1;

	// Timing
	localparam int CLK_HZ = 10_000_000;
	localparam int SCK_MAX_HZ = 2_000_000;
	localparam logic [3:0] MIN_HALF = 4'((CLK_HZ + 2 * SCK_MAX_HZ - 1) / (2 * SCK_MAX_HZ));

	// SRAM burst addressing
	localparam int MEM_AW = 12;
	localparam logic [3:0] BASE_LOW = 4'h0;

	// AXI responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {ENG_IDLE, ENG_SHIFT, ENG_TAIL} eng_e;
	typedef enum logic [1:0] {MEM_NONE, MEM_FETCH, MEM_WAIT, MEM_LOAD} mem_e;

endpackage

// ### src/spi_burst_port.sv
// Serial peripheral port: master/slave shifter, buffered mode and SRAM burst mode.
// Assumes a single-cycle-latency byte SRAM port and pins already synchronous-free (synced here).
`timescale 1ns/1ps
module spi_burst_port
(
	// Clock and reset
	input wire logic I_CLK,
	input wire logic I_RST,
	// AXI4-Lite write
	input wire logic I_AWVALID,
	output logic O_AWREADY,
	input wire logic [spi_burst_pkg::ADDR_W-1:0] I_AWADDR,
	input wire logic I_WVALID,
	output logic O_WREADY,
	input wire logic [31:0] I_WDATA,
	input wire logic [3:0] I_WSTRB,
	output logic O_BVALID,
	input wire logic I_BREADY,
	output logic [1:0] O_BRESP,
	// AXI4-Lite read
	input wire logic I_ARVALID,
	output logic O_ARREADY,
	input wire logic [spi_burst_pkg::ADDR_W-1:0] I_ARADDR,
	output logic O_RVALID,
	input wire logic I_RREADY,
	output logic [31:0] O_RDATA,
	output logic [1:0] O_RRESP,
	// Serial pins
	input wire logic I_SCLK,
	output logic O_SCLK,
	output logic O_SCLK_OE,
	input wire logic I_CS_N,
	output logic O_CS_N,
	output logic O_CS_N_OE,
	input wire logic I_MOSI,
	output logic O_MOSI,
	output logic O_MOSI_OE,
	input wire logic I_MISO,
	output logic O_MISO,
	output logic O_MISO_OE,
	// SRAM burst port
	output logic [spi_burst_pkg::MEM_AW-1:0] O_MEM_ADDR,
	output logic O_MEM_RD,
	output logic O_MEM_WR,
	output logic [7:0] O_MEM_WDATA,
	input wire logic [7:0] I_MEM_RDATA,
	// Interrupt and pin choice
	output logic O_IRQ,
	output logic O_IRQ_HIGH,
	output logic [1:0] O_PIN_CHOICE
);

	typedef struct packed {
		logic [7:0] cfg1;
		logic [7:0] cfg2;
		logic [7:0] tx_base;
		logic [7:0] rx_base;
		logic [7:0] cnt_lo;
		logic [3:0] cnt_hi;
		logic [1:0] pin_sel;
		logic rxclk_sel;
		logic rx_full;
		logic ovr;
		logic tx_empty;
		logic irq_flag;
		logic irq_allow;
		logic irq_rank;
		logic [7:0] rx_buf;
		logic [7:0] tx_buf;
		logic [7:0] tx_shift;
		logic [7:0] rx_shift;
		logic shift_full;
		logic [3:0] bit_cnt;
		logic [3:0] edge_cnt;
		logic [3:0] half_cnt;
		logic sclk;
		logic out_bit;
		spi_burst_pkg::eng_e eng;
		spi_burst_pkg::mem_e mem_ph;
		logic [11:0] tx_addr;
		logic [11:0] rx_addr;
		logic [11:0] done_cnt;
		logic [11:0] mem_addr;
		logic mem_rd;
		logic mem_wr;
		logic [7:0] mem_wdata;
		logic sclk_s1;
		logic sclk_s2;
		logic sclk_s3;
		logic cs_s1;
		logic cs_s2;
		logic cs_s3;
		logic mosi_s1;
		logic mosi_s2;
		logic miso_s1;
		logic miso_s2;
		logic aw_held;
		logic [7:0] aw_idx;
		logic w_held;
		logic [7:0] wdata;
		logic wstrb0;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [7:0] rdata;
		logic [1:0] rresp;
	} state_s;

	state_s r;
	state_s n;

	logic en, master, cpol, cpha, lsbf, half, dir, echo, burst;
	logic [3:0] half_len;
	logic [3:0] div_len;
	logic pad_e, pad_l, slave_e, rx_in, port_idle;
	logic [11:0] target;

	// Drive step: {bit now on the line, shifter after it}
	function automatic logic [8:0] drive_f(input logic [7:0] v, input logic lsb);
		drive_f = lsb ? {v[0], 1'b0, v[7:1]} : {v[7], v[6:0], 1'b0};
	endfunction

	function automatic logic [7:0] take_f(input logic [7:0] v, input logic b, input logic lsb);
		take_f = lsb ? {b, v[7:1]} : {v[6:0], b};
	endfunction

	function automatic logic mapped_f(input logic [7:0] idx);
		case (idx)
			spi_burst_pkg::IDX_TX_BASE, spi_burst_pkg::IDX_RX_BASE,
			spi_burst_pkg::IDX_CNT_LO, spi_burst_pkg::IDX_CNT_HI,
			spi_burst_pkg::IDX_PIN, spi_burst_pkg::IDX_RXCLK,
			spi_burst_pkg::IDX_CTRL1, spi_burst_pkg::IDX_CTRL2,
			spi_burst_pkg::IDX_FLAGS, spi_burst_pkg::IDX_DATA,
			spi_burst_pkg::IDX_IRQF, spi_burst_pkg::IDX_IRQE,
			spi_burst_pkg::IDX_IRQP: mapped_f = 1'b1;
			default: mapped_f = 1'b0;
		endcase
	endfunction

	assign en = r.cfg1[spi_burst_pkg::C1_EN];
	assign master = r.cfg1[spi_burst_pkg::C1_ROLE];
	assign cpol = r.cfg1[spi_burst_pkg::C1_POL];
	assign cpha = r.cfg1[spi_burst_pkg::C1_PHA];
	assign lsbf = r.cfg1[spi_burst_pkg::C1_LSB];
	assign half = r.cfg2[spi_burst_pkg::C2_HALF];
	assign dir = r.cfg2[spi_burst_pkg::C2_DIR];
	assign echo = r.cfg2[spi_burst_pkg::C2_ECHO];
	assign burst = r.cfg2[spi_burst_pkg::C2_GO];
	assign target = {r.cnt_hi, r.cnt_lo};

	// Half period of field+1 cycles, floored so the clock stays at or below 2 MHz
	assign div_len = {1'b0, r.cfg2[2:0]} + 4'h1;
	assign half_len = (div_len < spi_burst_pkg::MIN_HALF) ? spi_burst_pkg::MIN_HALF : div_len;

	// Pad clock edges, read only from the second and third sync stages
	assign pad_e = r.sclk_s2 ^ r.sclk_s3;
	assign pad_l = (r.sclk_s3 == cpol);
	assign slave_e = pad_e & en & ~master & ~r.cs_s2;
	assign rx_in = (half | ~master) ? r.mosi_s2 : r.miso_s2;
	assign port_idle = master ? (r.eng == spi_burst_pkg::ENG_IDLE) : r.cs_s2;

	always_comb
	begin
		logic int_e, int_l, drv, smp, done, ld, wr_go, wr_en, data_wr;
		logic [7:0] rx_new, ld_val, wd, rd;
		int_e = 1'b0;
		int_l = 1'b0;
		drv = 1'b0;
		smp = 1'b0;
		done = 1'b0;
		ld = 1'b0;
		wr_go = 1'b0;
		wr_en = 1'b0;
		data_wr = 1'b0;
		rx_new = r.rx_shift;
		ld_val = r.tx_buf;
		wd = r.wdata;
		rd = 8'h00;
		n = r;

		n.sclk_s1 = I_SCLK;
		n.sclk_s2 = r.sclk_s1;
		n.sclk_s3 = r.sclk_s2;
		n.cs_s1 = I_CS_N;
		n.cs_s2 = r.cs_s1;
		n.cs_s3 = r.cs_s2;
		n.mosi_s1 = I_MOSI;
		n.mosi_s2 = r.mosi_s1;
		n.miso_s1 = I_MISO;
		n.miso_s2 = r.miso_s1;
		n.mem_rd = 1'b0;
		n.mem_wr = 1'b0;

		// Bus slave: address and data held until both present
		if (I_AWVALID && O_AWREADY)
		begin
			n.aw_held = 1'b1;
			n.aw_idx = I_AWADDR[spi_burst_pkg::ADDR_W-1:2];
		end
		if (I_WVALID && O_WREADY)
		begin
			n.w_held = 1'b1;
			n.wdata = I_WDATA[7:0];
			n.wstrb0 = I_WSTRB[0];
		end
		wr_go = r.aw_held & r.w_held & ~r.bvalid;
		wr_en = wr_go & r.wstrb0;
		if (wr_go)
		begin
			n.aw_held = 1'b0;
			n.w_held = 1'b0;
			n.bvalid = 1'b1;
			n.bresp = mapped_f(r.aw_idx) ? spi_burst_pkg::RESP_OKAY : spi_burst_pkg::RESP_SLVERR;
		end
		else if (r.bvalid && I_BREADY)
		begin
			n.bvalid = 1'b0;
		end

		case (I_ARADDR[spi_burst_pkg::ADDR_W-1:2])
			spi_burst_pkg::IDX_TX_BASE: rd = r.tx_base;
			spi_burst_pkg::IDX_RX_BASE: rd = r.rx_base;
			spi_burst_pkg::IDX_CNT_LO: rd = r.cnt_lo;
			spi_burst_pkg::IDX_CNT_HI: rd = {4'h0, r.cnt_hi};
			spi_burst_pkg::IDX_PIN: rd = {6'h00, r.pin_sel};
			spi_burst_pkg::IDX_RXCLK: rd = {7'h00, r.rxclk_sel};
			spi_burst_pkg::IDX_CTRL1: rd = r.cfg1;
			spi_burst_pkg::IDX_CTRL2: rd = r.cfg2;
			spi_burst_pkg::IDX_FLAGS: rd = {5'h00, r.rx_full, r.ovr, r.tx_empty};
			spi_burst_pkg::IDX_DATA: rd = r.rx_buf;
			spi_burst_pkg::IDX_IRQF: rd = {2'h0, r.irq_flag, 5'h00};
			spi_burst_pkg::IDX_IRQE: rd = {2'h0, r.irq_allow, 5'h00};
			spi_burst_pkg::IDX_IRQP: rd = {2'h0, r.irq_rank, 5'h00};
			default: rd = 8'h00;
		endcase
		if (I_ARVALID && O_ARREADY)
		begin
			n.rvalid = 1'b1;
			n.rdata = rd;
			n.rresp = mapped_f(I_ARADDR[spi_burst_pkg::ADDR_W-1:2]) ?
				spi_burst_pkg::RESP_OKAY : spi_burst_pkg::RESP_SLVERR;
		end
		else if (r.rvalid && I_RREADY)
		begin
			n.rvalid = 1'b0;
		end

		// Software writes come first so that hardware sets in this cycle win
		if (wr_en)
		begin
			case (r.aw_idx)
				spi_burst_pkg::IDX_TX_BASE: n.tx_base = wd;
				spi_burst_pkg::IDX_RX_BASE: n.rx_base = wd;
				spi_burst_pkg::IDX_CNT_LO: n.cnt_lo = wd;
				spi_burst_pkg::IDX_CNT_HI: n.cnt_hi = wd[3:0];
				spi_burst_pkg::IDX_PIN: n.pin_sel = wd[1:0];
				spi_burst_pkg::IDX_RXCLK: n.rxclk_sel = wd[0];
				spi_burst_pkg::IDX_CTRL1: n.cfg1 = wd;
				spi_burst_pkg::IDX_CTRL2:
				begin
					n.cfg2 = {1'b0, wd[6:0]};
					if (wd[spi_burst_pkg::C2_GO] && !burst)
					begin
						n.tx_addr = {r.tx_base, spi_burst_pkg::BASE_LOW};
						n.rx_addr = {r.rx_base, spi_burst_pkg::BASE_LOW};
						n.done_cnt = 12'h000;
						n.shift_full = 1'b0;
						n.mem_ph = spi_burst_pkg::MEM_FETCH;
					end
					else if (!wd[spi_burst_pkg::C2_GO])
					begin
						n.mem_ph = spi_burst_pkg::MEM_NONE;
					end
				end
				spi_burst_pkg::IDX_FLAGS:
				begin
					if (!wd[spi_burst_pkg::ST_FULL])
					begin
						n.rx_full = 1'b0;
					end
					if (!wd[spi_burst_pkg::ST_OVR])
					begin
						n.ovr = 1'b0;
					end
				end
				spi_burst_pkg::IDX_DATA: data_wr = 1'b1;
				spi_burst_pkg::IDX_IRQF: n.irq_flag = wd[spi_burst_pkg::IRQ_BIT];
				spi_burst_pkg::IDX_IRQE: n.irq_allow = wd[spi_burst_pkg::IRQ_BIT];
				spi_burst_pkg::IDX_IRQP: n.irq_rank = wd[spi_burst_pkg::IRQ_BIT];
				default: ;
			endcase
		end

		// Master clock generator
		unique case (r.eng)
			spi_burst_pkg::ENG_IDLE:
			begin
				n.sclk = cpol;
				n.edge_cnt = 4'h0;
				if (en && master && r.shift_full)
				begin
					n.eng = spi_burst_pkg::ENG_SHIFT;
					n.half_cnt = half_len - 4'h1;
					n.bit_cnt = 4'h0;
					if (!cpha)
					begin
						{n.out_bit, n.tx_shift} = drive_f(r.tx_shift, lsbf);
					end
				end
			end
			spi_burst_pkg::ENG_SHIFT:
			begin
				if (r.half_cnt == 4'h0)
				begin
					int_e = 1'b1;
					int_l = (r.sclk == cpol);
					n.sclk = ~r.sclk;
					n.edge_cnt = r.edge_cnt + 4'h1;
					n.half_cnt = half_len - 4'h1;
					if (r.edge_cnt == 4'hF)
					begin
						n.eng = spi_burst_pkg::ENG_TAIL;
					end
				end
				else
				begin
					n.half_cnt = r.half_cnt - 4'h1;
				end
			end
			spi_burst_pkg::ENG_TAIL:
			begin
				// Pad-clock capture may lag; wait for the last bit before the next byte
				if (r.half_cnt != 4'h0)
				begin
					n.half_cnt = r.half_cnt - 4'h1;
				end
				else if (r.bit_cnt == 4'h0)
				begin
					n.eng = spi_burst_pkg::ENG_IDLE;
				end
			end
		endcase

		// Drive on the edge that is not the sampling one
		if (master)
		begin
			drv = int_e & ~(int_l ^ cpha);
			smp = r.rxclk_sel ? (int_e & (int_l ^ cpha)) :
				(pad_e & (pad_l ^ cpha) & (r.eng != spi_burst_pkg::ENG_IDLE));
		end
		else
		begin
			drv = slave_e & ~(pad_l ^ cpha);
			smp = slave_e & (pad_l ^ cpha);
		end
		if (!cpha && (r.bit_cnt == 4'h0 || r.bit_cnt[3]))
		begin
			drv = 1'b0;
		end
		if (drv)
		begin
			{n.out_bit, n.tx_shift} = drive_f(r.tx_shift, lsbf);
		end
		if (smp)
		begin
			rx_new = take_f(r.rx_shift, rx_in, lsbf);
			n.rx_shift = rx_new;
			n.bit_cnt = r.bit_cnt + 4'h1;
			if (r.bit_cnt == 4'h7)
			begin
				done = 1'b1;
				n.bit_cnt = 4'h0;
			end
		end

		// Byte boundary
		if (done && burst)
		begin
			n.mem_wr = 1'b1;
			n.mem_addr = r.rx_addr;
			n.mem_wdata = rx_new;
			n.rx_addr = r.rx_addr + 12'h001;
			n.done_cnt = r.done_cnt + 12'h001;
			n.shift_full = 1'b0;
			if (r.done_cnt + 12'h001 == target)
			begin
				n.cfg2[spi_burst_pkg::C2_GO] = 1'b0;
				n.rx_full = 1'b1;
				n.tx_empty = 1'b1;
				n.irq_flag = 1'b1;
				n.mem_ph = spi_burst_pkg::MEM_NONE;
			end
			else if (echo)
			begin
				ld = 1'b1;
				ld_val = rx_new;
			end
			else
			begin
				n.mem_ph = spi_burst_pkg::MEM_FETCH;
			end
		end
		else if (done)
		begin
			if (r.rx_full)
			begin
				n.ovr = 1'b1;
			end
			else
			begin
				n.rx_buf = rx_new;
				n.rx_full = 1'b1;
				if (r.cfg1[spi_burst_pkg::C1_FULL_IE])
				begin
					n.irq_flag = 1'b1;
				end
			end
			if (echo)
			begin
				ld = 1'b1;
				ld_val = rx_new;
			end
			else if (!r.tx_empty)
			begin
				ld = 1'b1;
				n.tx_empty = 1'b1;
			end
			else
			begin
				n.shift_full = 1'b0;
			end
		end

		// SRAM fetch: read issued, data one cycle later
		unique case (r.mem_ph)
			spi_burst_pkg::MEM_NONE: ;
			spi_burst_pkg::MEM_FETCH:
			begin
				n.mem_rd = 1'b1;
				n.mem_addr = r.tx_addr;
				n.tx_addr = r.tx_addr + 12'h001;
				n.mem_ph = spi_burst_pkg::MEM_WAIT;
			end
			spi_burst_pkg::MEM_WAIT: n.mem_ph = spi_burst_pkg::MEM_LOAD;
			spi_burst_pkg::MEM_LOAD:
			begin
				ld = 1'b1;
				ld_val = I_MEM_RDATA;
				n.mem_ph = spi_burst_pkg::MEM_NONE;
			end
		endcase

		// Buffered write path: shifter first when idle, else the buffer
		if (data_wr && !burst)
		begin
			if (!n.shift_full && !ld && port_idle)
			begin
				ld = 1'b1;
				ld_val = wd;
			end
			else
			begin
				n.tx_buf = wd;
				n.tx_empty = 1'b0;
			end
		end
		if (ld)
		begin
			n.tx_shift = ld_val;
			n.shift_full = 1'b1;
			// A slave must present the first bit before the master's first edge
			if (!master && !cpha)
			begin
				{n.out_bit, n.tx_shift} = drive_f(ld_val, lsbf);
			end
		end

		if (r.cfg1[spi_burst_pkg::C1_EMPTY_IE] && n.tx_empty &&
			(!r.tx_empty || (n.cfg1[spi_burst_pkg::C1_EN] && !en)))
		begin
			n.irq_flag = 1'b1;
		end
		// A slave frame aborted by chip select restarts at bit zero
		if (!master && r.cs_s2 && !r.cs_s3)
		begin
			n.bit_cnt = 4'h0;
		end
		if (!en)
		begin
			n.eng = spi_burst_pkg::ENG_IDLE;
			n.bit_cnt = 4'h0;
			n.sclk = cpol;
		end
	end

	always_ff @(posedge I_CLK)
	begin
		if (I_RST)
		begin
			r <= '0;
			r.cfg1 <= spi_burst_pkg::CTRL1_RST;
			r.cfg2 <= spi_burst_pkg::CTRL2_RST;
			{r.rx_full, r.ovr, r.tx_empty} <= spi_burst_pkg::FLAGS_RST;
			r.eng <= spi_burst_pkg::ENG_IDLE;
			r.mem_ph <= spi_burst_pkg::MEM_NONE;
			r.cs_s1 <= 1'b1;
			r.cs_s2 <= 1'b1;
			r.cs_s3 <= 1'b1;
		end
		else
		begin
			r <= n;
		end
	end

	assign O_AWREADY = ~r.aw_held & ~r.bvalid;
	assign O_WREADY = ~r.w_held & ~r.bvalid;
	assign O_BVALID = r.bvalid;
	assign O_BRESP = r.bresp;
	assign O_ARREADY = ~r.rvalid;
	assign O_RVALID = r.rvalid;
	assign O_RDATA = {24'h000000, r.rdata};
	assign O_RRESP = r.rresp;

	assign O_SCLK = r.sclk;
	assign O_SCLK_OE = en & master;
	assign O_CS_N = r.cfg1[spi_burst_pkg::C1_CS];
	assign O_CS_N_OE = master;
	assign O_MOSI = r.out_bit;
	assign O_MOSI_OE = en & (half ? (dir & (master | ~r.cs_s2)) : master);
	assign O_MISO = r.out_bit;
	assign O_MISO_OE = en & ~master & ~r.cs_s2 & ~half;

	assign O_MEM_ADDR = r.mem_addr;
	assign O_MEM_RD = r.mem_rd;
	assign O_MEM_WR = r.mem_wr;
	assign O_MEM_WDATA = r.mem_wdata;

	assign O_IRQ = r.irq_flag & r.irq_allow;
	assign O_IRQ_HIGH = r.irq_rank;
	assign O_PIN_CHOICE = r.pin_sel;

endmodule // spi_burst_port

// ### sim/spi_burst_chk.sv
// Concurrent checks on the port's bus handshakes, clock pacing and SRAM strobes.
// Assumes it is bound onto spi_burst_port and sees only that module's ports.
`timescale 1ns/1ps
module spi_burst_chk
(
	// Clock and reset
	input wire logic I_CLK,
	input wire logic I_RST,
	// Register bus
	input wire logic I_AWVALID,
	input wire logic O_AWREADY,
	input wire logic I_WVALID,
	input wire logic O_WREADY,
	input wire logic O_BVALID,
	input wire logic I_BREADY,
	input wire logic [1:0] O_BRESP,
	input wire logic I_ARVALID,
	input wire logic O_ARREADY,
	input wire logic O_RVALID,
	input wire logic I_RREADY,
	input wire logic [31:0] O_RDATA,
	// Pins and SRAM strobes
	input wire logic O_SCLK,
	input wire logic O_SCLK_OE,
	input wire logic O_CS_N_OE,
	input wire logic O_MISO_OE,
	input wire logic O_MEM_RD,
	input wire logic O_MEM_WR
);
	default clocking cb @(posedge I_CLK);
	endclocking
	default disable iff (I_RST);
	sequence s_both_taken;
		I_AWVALID && O_AWREADY && I_WVALID && O_WREADY;
	endsequence
	sequence s_answer;
		!O_BVALID ##1 O_BVALID;
	endsequence
	sequence s_store;
		O_MEM_WR && !O_MEM_RD ##1 !O_MEM_WR;
	endsequence
	a_write_answer: assert property (s_both_taken |=> s_answer)
		else $error("write answer not two cycles after request");
	a_read_answer: assert property (I_ARVALID && O_ARREADY |=> O_RVALID && !O_ARREADY)
		else $error("read answer late");
	a_bresp_hold: assert property (O_BVALID && !I_BREADY |=> O_BVALID && $stable(O_BRESP))
		else $error("write answer dropped early");
	a_rdata_hold: assert property (O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA))
		else $error("read answer dropped early");
	a_bus_block: assert property (O_BVALID |-> !O_AWREADY && !O_WREADY)
		else $error("write taken while answer pending");
	a_rdata_upper: assert property (O_RVALID |-> O_RDATA[31:8] == 24'h0)
		else $error("upper read bits not zero");
	a_sclk_half: assert property (O_SCLK_OE && $changed(O_SCLK) |=> $stable(O_SCLK)[*2])
		else $error("serial clock half period too short");
	a_master_miso: assert property (O_CS_N_OE |-> !O_MISO_OE)
		else $error("master drives its input line");
	a_store_pulse: assert property (O_MEM_WR |-> s_store)
		else $error("SRAM store strobe not a lone pulse");
endmodule // spi_burst_chk

// ### sim/spi_far_slave.sv
// Far-side slave device: one byte per eight clocks, any polarity, phase and order.
// Assumes the port as master drives clock and chip select; frame bytes are seed plus index.
`timescale 1ns/1ps
module spi_far_slave
(
	// Serial pins
	input wire logic i_sclk,
	input wire logic i_cs_n,
	input wire logic i_mosi,
	output logic o_miso,
	// Mode and first byte of a frame
	input wire logic i_cpol,
	input wire logic i_pha,
	input wire logic i_lsb,
	input wire logic [7:0] i_seed
);
	logic [7:0] tx_r = 8'h00;
	logic [7:0] rx_r = 8'h00;
	logic [7:0] rx_log [0:7];
	logic cur = 1'h0;
	int bit_cnt = 0;
	int byte_cnt = 0;
	// Released line flips, so a stale bit never passes for data
	assign o_miso = i_cs_n ? ~cur : cur;
	always @(negedge i_cs_n)
	begin
		bit_cnt = 0;
		byte_cnt = 0;
		tx_r = i_seed;
		if (!i_pha)
			cur = i_lsb ? tx_r[0] : tx_r[7];
	end
	always @(i_sclk)
		if (!i_cs_n)
		begin
			if ((i_sclk != i_cpol) != i_pha)
			begin
				rx_r[i_lsb ? bit_cnt : 7 - bit_cnt] = i_mosi;
				bit_cnt++;
				if (bit_cnt == 8)
				begin
					rx_log[byte_cnt % 8] = rx_r;
					byte_cnt++;
					bit_cnt = 0;
					tx_r = i_seed + 8'(byte_cnt);
				end
			end
			else
				cur = i_lsb ? tx_r[bit_cnt] : tx_r[7 - bit_cnt];
		end
endmodule // spi_far_slave

// ### sim/tb_top.sv
// Bench for the serial port: bus tasks, far-side slave, byte SRAM and a slave-mode link master.
// Assumes a 100 ns system clock; the bench's own link clock runs at 800 ns inside frames.
`timescale 1ns/1ps
module tb_top;
	logic clk = 1'h0;
	logic rst = 1'h1;
	logic awv = 1'h0, wv = 1'h0, bre = 1'h0, arv = 1'h0, rre = 1'h0;
	logic [9:0] awa = 10'h0, ara = 10'h0;
	logic [31:0] wd = 32'h0, rd;
	logic awr, wrdy, bv, arr, rv, sclk_o, sclk_oe, cs_o, cs_oe, mosi_o, mosi_oe, miso_o, miso_oe;
	logic mrd, mwr, irq, irq_hi, sclk_q;
	logic [1:0] bresp, rresp, pin;
	logic [11:0] maddr;
	logic [7:0] mwd, mrdata, seed;
	logic [7:0] mem [0:4095];
	logic m_sclk = 1'h0, m_cs_n = 1'h1, m_mosi = 1'h0, cpol = 1'h0, pha = 1'h0, lsb = 1'h0;
	wire far_miso;
	wire sclk_w = sclk_oe ? sclk_o : m_sclk;
	wire cs_w = cs_oe ? cs_o : m_cs_n;
	wire far_cs = cs_oe ? cs_o : 1'h1;
	wire mosi_w = mosi_oe ? mosi_o : m_mosi;
	wire miso_w = miso_oe ? miso_o : far_miso;
	int error_cnt = 0, comparisons = 0, cyc = 0, hcnt = 0, last_half = 0;

	spi_burst_port i_spi_burst_port
	(
		.I_CLK(clk), .I_RST(rst), .I_AWVALID(awv), .O_AWREADY(awr), .I_AWADDR(awa),
		.I_WVALID(wv), .O_WREADY(wrdy), .I_WDATA(wd), .I_WSTRB(4'hF), .O_BVALID(bv),
		.I_BREADY(bre), .O_BRESP(bresp), .I_ARVALID(arv), .O_ARREADY(arr), .I_ARADDR(ara),
		.O_RVALID(rv), .I_RREADY(rre), .O_RDATA(rd), .O_RRESP(rresp), .I_SCLK(sclk_w),
		.O_SCLK(sclk_o), .O_SCLK_OE(sclk_oe), .I_CS_N(cs_w), .O_CS_N(cs_o), .O_CS_N_OE(cs_oe),
		.I_MOSI(mosi_w), .O_MOSI(mosi_o), .O_MOSI_OE(mosi_oe), .I_MISO(miso_w), .O_MISO(miso_o),
		.O_MISO_OE(miso_oe), .O_MEM_ADDR(maddr), .O_MEM_RD(mrd), .O_MEM_WR(mwr),
		.O_MEM_WDATA(mwd), .I_MEM_RDATA(mrdata), .O_IRQ(irq), .O_IRQ_HIGH(irq_hi),
		.O_PIN_CHOICE(pin)
	);

	spi_far_slave i_spi_far_slave
	(
		.i_sclk(sclk_w), .i_cs_n(far_cs), .i_mosi(mosi_w), .o_miso(far_miso),
		.i_cpol(cpol), .i_pha(pha), .i_lsb(lsb), .i_seed(seed)
	);

	always #50 clk = ~clk;

	// SRAM with one cycle of read latency, clock half-period meter, watchdog
	always @(posedge clk)
	begin
		if (mrd)
			mrdata <= mem[maddr];
		if (mwr)
			mem[maddr] <= mwd;
		hcnt <= (sclk_o !== sclk_q) ? 1 : hcnt + 1;
		if (sclk_o !== sclk_q)
			last_half <= hcnt;
		sclk_q <= sclk_o;
		cyc <= cyc + 1;
		if (cyc == 60000)
		begin
			error_cnt++;
			final_report();
		end
	end

	task automatic final_report();
		if (error_cnt == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er = 2'h0);
		logic done;
		@(posedge clk);
		done = 1'h0;
		awv <= 1'h1;
		wv <= 1'h1;
		bre <= 1'h1;
		awa <= {idx, 2'h0};
		wd <= {24'h0, d};
		while (!done)
		begin
			@(posedge clk);
			if (awv && awr)
				awv <= 1'h0;
			if (wv && wrdy)
				wv <= 1'h0;
			if (bv && bre)
			begin
				done = 1'h1;
				bre <= 1'h0;
				chk(bresp, er);
			end
		end
	endtask

	task automatic rdr(input logic [7:0] idx, output logic [7:0] d, input logic [1:0] er = 2'h0);
		logic done;
		@(posedge clk);
		done = 1'h0;
		arv <= 1'h1;
		rre <= 1'h1;
		ara <= {idx, 2'h0};
		while (!done)
		begin
			@(posedge clk);
			if (arv && arr)
				arv <= 1'h0;
			if (rv && rre)
			begin
				done = 1'h1;
				rre <= 1'h0;
				d = rd[7:0];
				chk(rresp, er);
			end
		end
	endtask

	task automatic rc(input logic [7:0] idx, input logic [7:0] exp);
		logic [7:0] d;
		rdr(idx, d);
		chk(d, exp);
	endtask

	task automatic poll(input logic [7:0] idx, input int b, input logic v);
		logic [7:0] d;
		rdr(idx, d);
		while (d[b] !== v)
			rdr(idx, d);
	endtask

	// Mode 0 link master, 800 ns clock only inside the frame; samples on the rising edge
	task automatic sxfer(input logic [7:0] mo, output logic [7:0] mi);
		@(posedge clk);
		m_cs_n <= 1'h0;
		for (int i = 0; i < 8; i++)
		begin
			m_mosi <= mo[7 - i];
			repeat (4) @(posedge clk);
			mi[7 - i] = miso_w;
			m_sclk <= 1'h1;
			repeat (4) @(posedge clk);
			m_sclk <= 1'h0;
		end
		repeat (4) @(posedge clk);
		m_cs_n <= 1'h1;
	endtask

	initial
	begin
		logic [7:0] d, cfg;
		for (int k = 0; k < 3; k++)
			mem[12'h020 + k] = 8'hD0 + 8'(k);
		repeat (8) @(posedge clk);
		rst <= 1'h0;
		rc(spi_burst_pkg::IDX_CTRL1, spi_burst_pkg::CTRL1_RST);
		rc(spi_burst_pkg::IDX_CTRL2, spi_burst_pkg::CTRL2_RST);
		rc(spi_burst_pkg::IDX_FLAGS, 8'h01);
		rc(spi_burst_pkg::IDX_DATA, 8'h00);
		rc(spi_burst_pkg::IDX_CNT_HI, 8'h00);
		rdr(8'h00, d, spi_burst_pkg::RESP_SLVERR);
		wr(8'h01, 8'hFF, spi_burst_pkg::RESP_SLVERR);
		wr(spi_burst_pkg::IDX_IRQP, 8'h20);
		wr(spi_burst_pkg::IDX_PIN, 8'h02);
		chk(irq_hi, 1'h1);
		chk(pin, 2'h2);
		// Every polarity, phase and order as master; last one slow on the pad clock
		for (int m = 0; m < 8; m++)
		begin
			{cpol, pha, lsb} = 3'(m);
			seed = 8'h3C + 8'(m);
			cfg = {4'h5, 3'(m), 1'h1};
			wr(spi_burst_pkg::IDX_CTRL1, cfg);
			wr(spi_burst_pkg::IDX_RXCLK, (m == 7) ? 8'h00 : 8'h01);
			wr(spi_burst_pkg::IDX_CTRL2, (m == 7) ? 8'h07 : 8'h00);
			chk(cs_o, 1'h1);
			wr(spi_burst_pkg::IDX_CTRL1, cfg & 8'hFE);
			wr(spi_burst_pkg::IDX_DATA, 8'hA0 + 8'(m));
			chk(cs_o, 1'h0);
			poll(spi_burst_pkg::IDX_FLAGS, spi_burst_pkg::ST_FULL, 1'h1);
			rc(spi_burst_pkg::IDX_DATA, seed);
			chk(i_spi_far_slave.rx_log[0], 8'hA0 + 8'(m));
			chk(last_half, (m == 7) ? 8 : 3);
			wr(spi_burst_pkg::IDX_FLAGS, 8'h00);
			rc(spi_burst_pkg::IDX_FLAGS, 8'h01);
			wr(spi_burst_pkg::IDX_CTRL1, cfg);
		end
		// One-line duplex: the master drives the shared line only when sending
		wr(spi_burst_pkg::IDX_CTRL2, 8'h10);
		chk(mosi_oe, 1'h0);
		wr(spi_burst_pkg::IDX_CTRL2, 8'h18);
		chk(mosi_oe, 1'h1);
		chk(miso_oe, 1'h0);
		wr(spi_burst_pkg::IDX_CTRL2, 8'h07);
		// Slave: direct load, buffered byte, full interrupt, then overrun
		wr(spi_burst_pkg::IDX_IRQE, 8'h20);
		wr(spi_burst_pkg::IDX_CTRL1, 8'hC1);
		wr(spi_burst_pkg::IDX_DATA, 8'h96);
		rc(spi_burst_pkg::IDX_FLAGS, 8'h01);
		wr(spi_burst_pkg::IDX_DATA, 8'h33);
		rc(spi_burst_pkg::IDX_FLAGS, 8'h00);
		sxfer(8'h5A, d);
		chk(d, 8'h96);
		rc(spi_burst_pkg::IDX_FLAGS, 8'h05);
		chk(irq, 1'h1);
		wr(spi_burst_pkg::IDX_IRQF, 8'h00);
		chk(irq, 1'h0);
		sxfer(8'hC3, d);
		chk(d, 8'h33);
		rc(spi_burst_pkg::IDX_FLAGS, 8'h07);
		rc(spi_burst_pkg::IDX_DATA, 8'h5A);
		// Slave echo: each received byte goes back out in the next frame
		wr(spi_burst_pkg::IDX_CTRL2, 8'h47);
		sxfer(8'hE1, d);
		sxfer(8'h7E, d);
		chk(d, 8'hE1);
		wr(spi_burst_pkg::IDX_CTRL2, 8'h07);
		sxfer(8'h00, d);
		chk(d, 8'h7E);
		// Burst of three bytes between SRAM and the far slave
		{cpol, pha, lsb} = 3'h0;
		seed = 8'h60;
		wr(spi_burst_pkg::IDX_FLAGS, 8'h00);
		wr(spi_burst_pkg::IDX_IRQF, 8'h00);
		wr(spi_burst_pkg::IDX_TX_BASE, 8'h02);
		wr(spi_burst_pkg::IDX_RX_BASE, 8'h05);
		wr(spi_burst_pkg::IDX_CNT_LO, 8'h03);
		wr(spi_burst_pkg::IDX_RXCLK, 8'h01);
		wr(spi_burst_pkg::IDX_CTRL1, 8'h51);
		wr(spi_burst_pkg::IDX_CTRL1, 8'h50);
		chk(irq, 1'h0);
		wr(spi_burst_pkg::IDX_CTRL2, 8'h20);
		poll(spi_burst_pkg::IDX_CTRL2, spi_burst_pkg::C2_GO, 1'h0);
		for (int k = 0; k < 3; k++)
		begin
			chk(mem[12'h050 + k], 8'h60 + 8'(k));
			chk(i_spi_far_slave.rx_log[k], 8'hD0 + 8'(k));
		end
		rc(spi_burst_pkg::IDX_FLAGS, 8'h05);
		chk(irq, 1'h1);
		wr(spi_burst_pkg::IDX_CTRL1, 8'h51);
		// Empty allow set, then enable rising with an empty buffer raises the flag
		wr(spi_burst_pkg::IDX_CTRL1, 8'h31);
		wr(spi_burst_pkg::IDX_IRQF, 8'h00);
		chk(irq, 1'h0);
		wr(spi_burst_pkg::IDX_CTRL1, 8'h71);
		chk(irq, 1'h1);
		final_report();
	end
endmodule // tb_top

bind spi_burst_port spi_burst_chk i_spi_burst_chk
(
	.I_CLK, .I_RST, .I_AWVALID, .O_AWREADY, .I_WVALID, .O_WREADY, .O_BVALID, .I_BREADY,
	.O_BRESP, .I_ARVALID, .O_ARREADY, .O_RVALID, .I_RREADY, .O_RDATA, .O_SCLK, .O_SCLK_OE,
	.O_CS_N_OE, .O_MISO_OE, .O_MEM_RD, .O_MEM_WR
);
